// ===== hw/hsbf_map.svh
`ifndef HSBF_MAP_SVH
`define HSBF_MAP_SVH

// Register indices; byte address is four times the index
`define HSBF_DATA_IDX      10'h000
`define HSBF_STATUS_IDX    10'h001
`define HSBF_SPEED_IDX     10'h03b

// Speed register fields
`define HSBF_EXP_MSB       7
`define HSBF_EXP_LSB       5
`define HSBF_DIV_MSB       4
`define HSBF_DIV_LSB       0

// Speed reset value selects 9.6 kbit/s
`define HSBF_SPEED_RESET   8'heb

// Divisor offset used with a nonzero exponent
`define HSBF_DIV_OFFSET    13'h0021

// Status bit positions
`define HSBF_ST_RXVALID    0
`define HSBF_ST_TXFULL     1
`define HSBF_ST_TXBUSY     2
`define HSBF_ST_OVERRUN    3
`define HSBF_ST_FRAMEERR   4

// Reference and system clock rates in kHz (27120 and 20000)
`define HSBF_REF_KHZ       32'h000069f0
`define HSBF_CLK_KHZ       32'h00004e20

// Data bits per character and FIFO depth
`define HSBF_DATA_BITS     4'h8
`define HSBF_FIFO_DEPTH    32

`endif

// ===== hw/hsbf_pkg.sv
package hsbf_pkg;

    typedef logic [31:0] hsbf_word_t;
    typedef logic [7:0]  hsbf_byte_t;

    typedef enum logic [1:0] {
        REG_NONE   = 2'b00,
        REG_DATA   = 2'b01,
        REG_STATUS = 2'b10,
        REG_SPEED  = 2'b11
    } hsbf_reg_t;

    typedef struct packed {
        hsbf_reg_t target;
        logic      write;
    } hsbf_req_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } hsbf_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } hsbf_rx_state_t;

    typedef struct packed {
        logic frameErr;
        logic overrun;
        logic txBusy;
        logic txFull;
        logic rxValid;
    } hsbf_status_t;

endpackage : hsbf_pkg

// ===== hw/hsbf_fifo.sv
module hsbf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    import hsbf_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : hsbf_fifo

// ===== hw/hsbf_framer.sv
// Operation
// - After reset the serial link runs at 9.6 kbit/s.
// - Exponent zero: bit rate is 27.12 MHz over divisor plus one.
// - Exponent nonzero: 27.12 MHz over divisor plus 33, over two to exponent minus one.
// - Each character is start bit, eight data bits, stop bit, no parity.
// - Speed register is read/write and a write changes the bit rate.
`include "hsbf_map.svh"

module hsbf_framer (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire hsbf_pkg::hsbf_word_t hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output hsbf_pkg::hsbf_word_t   hrdata,
    // Serial pins
    input  wire logic              serialIn,
    output logic                   serialOut
);
    import hsbf_pkg::*;

    // Bit period in reference ticks scaled by the system clock rate.
    // The 20 MHz clock is slower than the reference, so the period is
    // tracked by a phase accumulator rather than a plain counter.
    function automatic logic [31:0] bitLimit(input hsbf_byte_t sel);
        logic [2:0]  expo;
        logic [12:0] div;
        logic [12:0] ticks;
        expo = sel[`HSBF_EXP_MSB:`HSBF_EXP_LSB];
        div  = {8'h00, sel[`HSBF_DIV_MSB:`HSBF_DIV_LSB]};
        if (expo == 3'h0) begin
            ticks = div + 13'h0001;
        end else begin
            ticks = (div + `HSBF_DIV_OFFSET) << (expo - 3'h1);
        end
        bitLimit = {19'h00000, ticks} * `HSBF_CLK_KHZ;
    endfunction : bitLimit

    function automatic hsbf_reg_t decodeReg(input logic [31:0] addr);
        if (addr[11:0] == {`HSBF_DATA_IDX, 2'b00}) begin
            decodeReg = REG_DATA;
        end else if (addr[11:0] == {`HSBF_STATUS_IDX, 2'b00}) begin
            decodeReg = REG_STATUS;
        end else if (addr[11:0] == {`HSBF_SPEED_IDX, 2'b00}) begin
            decodeReg = REG_SPEED;
        end else begin
            decodeReg = REG_NONE;
        end
    endfunction : decodeReg

    // Bus side state
    hsbf_req_t      req_q;
    logic           reqPend_q;
    logic           hreadyout_q;
    hsbf_word_t     hrdata_q;
    logic           hresp_q;
    hsbf_byte_t     speed_q;

    // Transmit side state
    hsbf_tx_state_t txState_q;
    logic [8:0]     txShift_q;
    logic [3:0]     txCount_q;
    logic [31:0]    txAcc_q;
    hsbf_byte_t     txSel_q;
    logic           txOut_q;

    // Receive side state
    hsbf_rx_state_t rxState_q;
    hsbf_byte_t     rxShift_q;
    logic [3:0]     rxCount_q;
    logic [31:0]    rxAcc_q;
    hsbf_byte_t     rxSel_q;
    hsbf_byte_t     rxData_q;
    logic           rxValid_q;
    logic           overrun_q;
    logic           frameErr_q;

    // Internal wiring
    logic           fifoInValid;
    logic           fifoInReady;
    logic           fifoOutValid;
    logic           fifoOutReady;
    hsbf_byte_t     fifoOutData;
    logic           stall;
    logic           done;
    logic           popRx;
    logic           clearStatus;
    logic [31:0]    txLimit;
    logic [31:0]    txSum;
    logic           txTick;
    logic [31:0]    rxLimit;
    logic [31:0]    rxSum;
    logic           rxTick;
    logic           rxDeliver;
    logic           rxBadStop;
    hsbf_status_t   status;
    hsbf_word_t     readValue;

    assign fifoInValid = reqPend_q && req_q.write && (req_q.target == REG_DATA);
    // Full FIFO holds the data phase with wait states
    assign stall       = fifoInValid && !fifoInReady;
    assign done        = reqPend_q && !stall;
    assign popRx       = done && !req_q.write && (req_q.target == REG_DATA);
    assign clearStatus = done && req_q.write && (req_q.target == REG_STATUS);

    assign status.frameErr = frameErr_q;
    assign status.overrun  = overrun_q;
    assign status.txBusy   = (txState_q != TX_IDLE) || fifoOutValid;
    assign status.txFull   = !fifoInReady;
    assign status.rxValid  = rxValid_q;

    always_comb begin
        readValue = '0;
        case (req_q.target)
            REG_DATA: begin
                readValue = {24'h000000, rxData_q};
            end
            REG_STATUS: begin
                readValue = {27'h0000000, status};
            end
            REG_SPEED: begin
                readValue = {24'h000000, speed_q};
            end
            default: begin
                readValue = '0;
            end
        endcase
    end

    // Address phase capture and data phase completion
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            req_q       <= '{target: REG_NONE, write: 1'b0};
            reqPend_q   <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q    <= '0;
            hresp_q     <= 1'b0;
        end else if (reqPend_q) begin
            if (done) begin
                reqPend_q   <= 1'b0;
                hreadyout_q <= 1'b1;
                hrdata_q    <= req_q.write ? '0 : readValue;
            end
        end else if (hsel && hready && htrans[1]) begin
            req_q       <= '{target: decodeReg(haddr), write: hwrite};
            reqPend_q   <= 1'b1;
            hreadyout_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            speed_q <= `HSBF_SPEED_RESET;
        end else if (done && req_q.write && (req_q.target == REG_SPEED)) begin
            speed_q <= hwdata[7:0];
        end
    end

    hsbf_fifo #(
        .WIDTH (8),
        .DEPTH (`HSBF_FIFO_DEPTH)
    ) txFifo (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (hwdata[7:0]),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    assign fifoOutReady = (txState_q == TX_IDLE);
    assign txLimit      = bitLimit(txSel_q);
    assign txSum        = txAcc_q + `HSBF_REF_KHZ;
    assign txTick       = (txSum >= txLimit);

    // Transmitter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txState_q <= TX_IDLE;
            txShift_q <= '0;
            txCount_q <= '0;
            txAcc_q   <= '0;
            txSel_q   <= `HSBF_SPEED_RESET;
            txOut_q   <= 1'b1;
        end else begin
            case (txState_q)
                TX_IDLE: begin
                    if (fifoOutValid) begin
                        txSel_q   <= speed_q;
                        txShift_q <= {1'b1, fifoOutData};
                        txOut_q   <= 1'b0;
                        txCount_q <= `HSBF_DATA_BITS + 4'h1;
                        txAcc_q   <= '0;
                        txState_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (txTick) begin
                        txAcc_q <= txSum - txLimit;
                        if (txCount_q == 4'h0) begin
                            txState_q <= TX_IDLE;
                        end else begin
                            txOut_q   <= txShift_q[0];
                            txShift_q <= {1'b1, txShift_q[8:1]};
                            txCount_q <= txCount_q - 4'h1;
                        end
                    end else begin
                        txAcc_q <= txSum;
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                    txOut_q   <= 1'b1;
                end
            endcase
        end
    end

    // First tick of a character lands mid start bit
    assign rxLimit   = (rxState_q == RX_START) ? (bitLimit(rxSel_q) >> 1) : bitLimit(rxSel_q);
    assign rxSum     = rxAcc_q + `HSBF_REF_KHZ;
    assign rxTick    = (rxSum >= rxLimit);
    assign rxDeliver = (rxState_q == RX_STOP) && rxTick && serialIn;
    assign rxBadStop = (rxState_q == RX_STOP) && rxTick && !serialIn;

    // Receiver
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxState_q <= RX_IDLE;
            rxShift_q <= '0;
            rxCount_q <= '0;
            rxAcc_q   <= '0;
            rxSel_q   <= `HSBF_SPEED_RESET;
            rxData_q  <= '0;
        end else begin
            case (rxState_q)
                RX_IDLE: begin
                    if (!serialIn) begin
                        rxSel_q   <= speed_q;
                        rxAcc_q   <= '0;
                        rxState_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rxTick) begin
                        rxAcc_q   <= '0;
                        rxCount_q <= '0;
                        // Glitch shorter than half a bit is dropped
                        rxState_q <= serialIn ? RX_IDLE : RX_DATA;
                    end else begin
                        rxAcc_q <= rxSum;
                    end
                end
                RX_DATA: begin
                    if (rxTick) begin
                        rxAcc_q   <= rxSum - rxLimit;
                        rxShift_q <= {serialIn, rxShift_q[7:1]};
                        rxCount_q <= rxCount_q + 4'h1;
                        if (rxCount_q == `HSBF_DATA_BITS - 4'h1) begin
                            rxState_q <= RX_STOP;
                        end
                    end else begin
                        rxAcc_q <= rxSum;
                    end
                end
                RX_STOP: begin
                    if (rxTick) begin
                        rxState_q <= RX_IDLE;
                        if (serialIn) begin
                            rxData_q <= rxShift_q;
                        end
                    end else begin
                        rxAcc_q <= rxSum;
                    end
                end
                default: begin
                    rxState_q <= RX_IDLE;
                end
            endcase
        end
    end

    // Received byte flag; a new byte wins over the read that clears it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxValid_q <= 1'b0;
        end else if (rxDeliver) begin
            rxValid_q <= 1'b1;
        end else if (popRx) begin
            rxValid_q <= 1'b0;
        end
    end

    // Sticky errors, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            overrun_q  <= 1'b0;
            frameErr_q <= 1'b0;
        end else begin
            if (rxDeliver && rxValid_q && !popRx) begin
                overrun_q <= 1'b1;
            end else if (clearStatus && hwdata[`HSBF_ST_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
            if (rxBadStop) begin
                frameErr_q <= 1'b1;
            end else if (clearStatus && hwdata[`HSBF_ST_FRAMEERR]) begin
                frameErr_q <= 1'b0;
            end
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign hrdata    = hrdata_q;
    assign serialOut = txOut_q;

endmodule : hsbf_framer

// ===== tb/hsbf_framer_monitor.sv
module hsbf_framer_monitor (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    // Bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire hsbf_pkg::hsbf_word_t hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire hsbf_pkg::hsbf_word_t hrdata,
    // Serial
    input wire logic                 serialIn,
    input wire logic                 serialOut
);
    timeunit 1ns;
    timeprecision 1ps;
    import hsbf_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_take; hsel && hready && htrans[1]; endsequence
    sequence s_answer; !hreadyout ##1 hreadyout; endsequence

    property p_okay; hresp == 1'b0; endproperty
    property p_rst; $fell(sys_rst) |-> serialOut && hreadyout && hrdata == 32'h0; endproperty
    property p_wait; s_take ##0 !hwrite |=> s_answer; endproperty
    property p_spdWr; s_take ##0 hwrite && haddr[11:0] == 12'h0ec |=> s_answer ##0 hrdata == 32'h0; endproperty
    property p_unm; s_take ##0 !hwrite && haddr[11:0] == 12'h100 |=> s_answer ##0 hrdata == 32'h0; endproperty
    property p_spdRd; s_take ##0 !hwrite && haddr[11:0] == 12'h0ec |=> s_answer ##0 hrdata[31:8] == 24'h0;
    endproperty
    property p_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
    // Even the fastest rate in the test, code 15, keeps a level for at least 16 cycles, more than the 8 checked
    property p_run; $changed(serialOut) |=> $stable(serialOut)[*7]; endproperty

    a_okay:
    assert property (p_okay) else $error("hresp not okay");
    a_rst:
    assert property (p_rst) else $error("bad levels after reset");
    a_wait:
    assert property (p_wait) else $error("read wait state wrong");
    a_spdWr:
    assert property (p_spdWr) else $error("speed write answer wrong");
    a_unm:
    assert property (p_unm) else $error("unmapped read not zero");
    a_spdRd:
    assert property (p_spdRd) else $error("speed upper bits set");
    a_hold:
    assert property (p_hold) else $error("hrdata moved outside answer");
    a_run:
    assert property (p_run) else $error("serial level too short");
endmodule : hsbf_framer_monitor

bind hsbf_framer hsbf_framer_monitor u_hsbf_framer_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serialIn(serialIn),
    .serialOut(serialOut));

// ===== tb/hsbf_host_uart.sv
module hsbf_host_uart (
    // Clock and lines
    input wire logic        ref_clk,
    input wire logic        serialOut,
    output logic            serialIn,
    // Bit period in cycles times 256
    input wire logic [31:0] per256,
    // Received characters
    output logic [7:0]      lastByte,
    output logic [31:0]     rxCount
);
    timeunit 1ns;
    timeprecision 1ps;
    real        bitNs;
    logic [7:0] sh;

    always_comb bitNs = real'(per256) * 50.0 / 256.0;
    initial begin
        serialIn = 1'b1;
        lastByte = 8'h00;
        rxCount = 32'h0;
    end

    // sample mid-bit, LSB first, stop high
    always begin
        @(negedge serialOut);
        #(bitNs * 1.5);
        for (int i = 0; i < 8; i++) begin
            sh[i] = serialOut;
            #(bitNs);
        end
        if (serialOut === 1'b1) begin
            lastByte = sh;
            rxCount = rxCount + 32'h1;
        end
    end

    task automatic send(input logic [7:0] b);
        @(negedge ref_clk);
        serialIn = 1'b0;
        #(bitNs);
        for (int i = 0; i < 8; i++) begin
            serialIn = b[i];
            #(bitNs);
        end
        serialIn = 1'b1;
        #(bitNs);
    endtask : send
endmodule : hsbf_host_uart

// ===== tb/hsbf_framer_tb.sv
`include "hsbf_map.svh"
module hsbf_framer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hsbf_pkg::*;
    typedef struct packed {logic [7:0] code; logic [31:0] ticks;} hsbf_row_t;
    localparam hsbf_word_t SPD = 32'(`HSBF_SPEED_IDX) << 2;
    localparam hsbf_word_t STA = 32'(`HSBF_STATUS_IDX) << 2;
    localparam hsbf_word_t DAT = 32'(`HSBF_DATA_IDX) << 2;
    // standard codes with reference ticks per bit
    hsbf_row_t  rows [6] = '{'{8'heb, 32'h0b00}, '{8'hfa, 32'h0ec0}, '{8'h7a, 32'h00ec},
                             '{8'h3a, 32'h003b}, '{8'h74, 32'h00d4}, '{8'h15, 32'h0016}};
    logic       ref_clk, sys_rst, hsel, hwrite, serialIn, serialOut, hreadyout, hresp;
    logic [31:0] haddr, per256, rxCount, c0;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] lastByte;
    hsbf_word_t hwdata, hrdata, rd;
    int         errors, testsRun, n;

    hsbf_framer u_hsbf_framer (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serialIn(serialIn), .serialOut(serialOut));
    hsbf_host_uart u_hsbf_host_uart (.ref_clk(ref_clk), .serialOut(serialOut), .serialIn(serialIn),
        .per256(per256), .lastByte(lastByte), .rxCount(rxCount));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Rows need about 53k cycles, the rest under 10k
    initial begin
        #(90000 * 50);
        errors++;
        $display("BAD %0t watchdog", $time);
        tally_and_finish();
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input hsbf_word_t got, input hsbf_word_t exp, input string m);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Accumulator jitter allows one cycle below and two cycles above
    task automatic chkNear(input int got, input int exp, input string m);
        testsRun++;
        if (got < exp - 1 || got > exp + 2) begin
            errors++;
            $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask : chkNear

    task automatic bus(input logic w, input hsbf_word_t a, input hsbf_word_t d);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic idle;
        do bus(1'b0, STA, 32'h0); while (rd[`HSBF_ST_TXBUSY] !== 1'b0);
    endtask : idle

    task automatic startBit(output int cnt);
        cnt = 0;
        do @(posedge ref_clk); while (serialOut !== 1'b0);
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (serialOut === 1'b0);
    endtask : startBit

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        per256 = 32'h0;
        errors = 0;
        testsRun = 0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, SPD, 32'h0); chk(rd, 32'h000000eb, "speed reset");
        bus(1'b0, 32'h100, 32'h0); chk(rd, 32'h0, "unmapped");
        $display("test reset done");
        foreach (rows[i]) begin
            idle();
            bus(1'b1, SPD, {24'h0, rows[i].code});
            bus(1'b0, SPD, 32'h0); chk(rd, {24'h0, rows[i].code}, "readback");
            bus(1'b1, DAT, 32'h55);
            startBit(n); chkNear(n, int'(rows[i].ticks) * 20000 / 27120, "bit period");
            $display("test row %0d done", i);
        end
        // Model stays deaf until the last row frame has ended
        idle();
        per256 = 32'(22 * 5120000 / 27120);
        c0 = rxCount;
        bus(1'b1, DAT, 32'ha5);
        do @(posedge ref_clk); while (serialOut !== 1'b0);
        bus(1'b1, SPD, 32'h3a);
        idle();
        chk({24'h0, lastByte}, 32'ha5, "mid-frame change");
        chk(rxCount, c0 + 32'h1, "frame count");
        bus(1'b1, SPD, 32'h15);
        $display("test speed change done");
        u_hsbf_host_uart.send(8'h3c);
        @(posedge ref_clk);
        bus(1'b0, STA, 32'h0); chk(rd & 32'h1f, 32'h1, "rx status");
        bus(1'b0, DAT, 32'h0); chk(rd, 32'h3c, "rx byte");
        bus(1'b0, STA, 32'h0); chk(rd & 32'h1, 32'h0, "rx cleared");
        $display("test receive done");
        u_hsbf_host_uart.send(8'h11);
        u_hsbf_host_uart.send(8'h22);
        @(posedge ref_clk);
        bus(1'b0, STA, 32'h0); chk(rd & 32'h1f, 32'h9, "overrun set");
        bus(1'b1, STA, 32'h8);
        bus(1'b0, STA, 32'h0); chk(rd & 32'h1f, 32'h1, "overrun cleared");
        bus(1'b0, DAT, 32'h0); chk(rd, 32'h22, "newest byte kept");
        $display("test overrun done");
        c0 = rxCount;
        for (int i = 0; i < 33; i++) bus(1'b1, DAT, 32'(i));
        bus(1'b0, STA, 32'h0); chk(rd & 32'h2, 32'h2, "fifo full");
        n = 0;
        fork
            bus(1'b1, DAT, 32'h21);
            forever begin
                @(posedge ref_clk);
                n++;
            end
        join_any
        disable fork;
        chk({31'h0, n > 20}, 32'h1, "full write stalls");
        idle();
        chk(rxCount, c0 + 32'd34, "drained count");
        chk({24'h0, lastByte}, 32'h21, "last byte");
        $display("test fifo done");
        bus(1'b1, SPD, 32'h3a);
        bus(1'b1, DAT, 32'h0f);
        do @(posedge ref_clk); while (serialOut !== 1'b0);
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk({31'h0, serialOut}, 32'h1, "line idle after reset");
        bus(1'b0, SPD, 32'h0); chk(rd, 32'h000000eb, "speed after reset");
        bus(1'b0, STA, 32'h0); chk(rd & 32'h1f, 32'h0, "status after reset");
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : hsbf_framer_tb
